/* common/interval_timer_cfg.svh */
// constants of the prescaled interval timer: offsets, field positions, resets
// assumes an 18-bit peripheral data and address bus
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// data and address width of the peripheral bus
`define TMR_DATA_W 18
`define TMR_ADDR_W 18

// peripheral space base and default base offset
`define TMR_PERIPH_BASE 18'h1A000
`define TMR_BASE_OFFSET 18'h00010

// register offsets (word index on the peripheral bus)
`define TMR_OFS_CONTROL 18'h00000
`define TMR_OFS_LIMIT 18'h00001
`define TMR_OFS_COUNT 18'h00002
`define TMR_NUM_REGS 18'h00003

// control field positions
`define TMR_RUN_BIT 0
`define TMR_DIV_EN_BIT 1
`define TMR_DIV_SEL_LSB 2
`define TMR_DIV_SEL_MSB 4
`define TMR_CTRL_W 5

// reset values
`define TMR_CTRL_RESET 5'h00
`define TMR_LIMIT_RESET 18'h00000
`define TMR_COUNT_RESET 18'h00000

// prescaler counter width: largest ratio is 2^8
`define TMR_DIV_W 8

`endif

/* common/interval_timer_pkg.sv */
// types shared by the interval timer and its prescaler
// assumes interval_timer_cfg.svh is on the include path
`include "interval_timer_cfg.svh"

package interval_timer_pkg;

  // control register fields, bit 0 at the bottom
  typedef struct packed {
    logic [2:0] divider_select;
    logic divider_enable_bit;
    logic count_run_bit;
  } ctrl_t;

  // build-time choice of what feeds the prescaler
  typedef enum logic [1:0] {
    SRC_SYSTEM,
    SRC_CLOCK_MANAGER,
    SRC_CASCADE
  } src_sel_t;

  // one request on the peripheral bus
  typedef struct packed {
    logic [`TMR_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [`TMR_DATA_W-1:0] wdata;
  } bus_req_t;

  // whole state of the timer
  typedef struct packed {
    ctrl_t ctrl;
    logic [`TMR_DATA_W-1:0] limit;
    logic [`TMR_DATA_W-1:0] count;
    logic src_prev;
    logic [`TMR_DATA_W-1:0] rdata;
  } timer_state_t;

  // whole state of the prescaler
  typedef struct packed {
    logic [`TMR_DIV_W-1:0] cnt;
  } div_state_t;

endpackage : interval_timer_pkg

/* hdl/tick_prescaler.sv */
// power-of-two prescaler for input ticks, ratio 2^(select+1)
// assumes ticks are one-cycle enables on clk
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

module tick_prescaler
  import interval_timer_pkg::*;
#(
  parameter int DIV_W = `TMR_DIV_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic tick_in,
  input wire logic [2:0] divider_select,
  output logic tick_out
);

  div_state_t state_reg;
  div_state_t state_next;
  logic [DIV_W:0] one_hot;
  logic [DIV_W-1:0] mask;

  // mask of low bits that must all be set for one output tick
  always_comb begin
    one_hot = (DIV_W+1)'({{DIV_W{1'b0}}, 1'b1} << ({1'b0, divider_select} + 4'h1));
    mask = DIV_W'(one_hot - (DIV_W+1)'(1));
  end

  // output one tick when the masked count rolls over
  assign tick_out = enable && tick_in && ((state_reg.cnt & mask) == mask);

  // count input ticks, clear while the prescaler is off
  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next.cnt = '0;
    end else if (tick_in) begin
      state_next.cnt = state_reg.cnt + DIV_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : tick_prescaler

/* hdl/prescaled_interval_timer.sv */
// prescaled interval timer: 18-bit up-counter behind a power-of-two prescaler,
// three registers on the processor peripheral bus
// assumes all inputs synchronous to clk; bus requests are single-cycle strobes
// a count write in the same cycle as a tick wins; that tick is lost
// the limit has no defined power-up value; zero is loaded on reset
// non-system sources count rising edges of a level sampled on clk
// a new divider select acts on the running prescaler count
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"

module prescaled_interval_timer
  import interval_timer_pkg::*;
#(
  parameter logic [`TMR_ADDR_W-1:0] base_offset_param = `TMR_BASE_OFFSET,
  parameter src_sel_t SOURCE = SRC_SYSTEM
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`TMR_ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`TMR_DATA_W-1:0] bus_wdata,
  output logic [`TMR_DATA_W-1:0] bus_rdata,
  input wire logic clock_manager_output,
  input wire logic cascade_in,
  output logic [`TMR_DATA_W-1:0] timer_output,
  output logic count_tick
);

  // whole registered state and its next value
  timer_state_t state_reg;
  timer_state_t state_next;

  // bus decode and read path
  bus_req_t req;
  logic [`TMR_ADDR_W-1:0] rel_addr;
  logic hit;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_count;
  logic sel_ctrl;
  logic sel_limit;
  logic sel_count;
  logic [`TMR_ADDR_W-1:0] window_base;
  logic [`TMR_DATA_W-1:0] ctrl_readback;

  // tick path
  logic src_level;
  logic src_tick;
  logic div_tick;
  logic raw_tick;
  logic run_tick;
  logic [`TMR_DATA_W-1:0] read_value;

  // counter step and control word as written
  ctrl_t ctrl_written;
  logic at_limit;
  logic [`TMR_DATA_W-1:0] count_inc;
  logic [`TMR_DATA_W-1:0] count_stepped;

  // bundle the bus pins into one request
  always_comb begin
    req.addr = bus_addr;
    req.wr = bus_wr;
    req.rd = bus_rd;
    req.wdata = bus_wdata;
  end

  // first word of this block's window
  assign window_base = `TMR_ADDR_W'(`TMR_PERIPH_BASE + base_offset_param);

  // address relative to this block's window
  always_comb begin
    rel_addr = req.addr - window_base;
    hit = (rel_addr < `TMR_NUM_REGS);
  end

  // which register the address selects
  always_comb begin
    sel_ctrl = hit && (rel_addr == `TMR_OFS_CONTROL);
    sel_limit = hit && (rel_addr == `TMR_OFS_LIMIT);
    sel_count = hit && (rel_addr == `TMR_OFS_COUNT);
  end

  // per-register write strobes
  always_comb begin
    wr_ctrl = req.wr && sel_ctrl;
    wr_limit = req.wr && sel_limit;
    wr_count = req.wr && sel_count;
  end

  // pick the prescaler source fixed at build time
  always_comb begin
    case (SOURCE)
      SRC_SYSTEM: src_level = 1'b0; // no level, ticks every cycle
      SRC_CLOCK_MANAGER: src_level = clock_manager_output;
      SRC_CASCADE: src_level = cascade_in;
      default: src_level = 1'b0;
    endcase
  end

  // system clock ticks every cycle; other sources tick on their rising edge
  always_comb begin
    if (SOURCE == SRC_SYSTEM) begin
      src_tick = 1'b1;
    end else begin
      src_tick = src_level && !state_reg.src_prev;
    end
  end

  // divider between source and counter
  tick_prescaler #(
    .DIV_W(`TMR_DIV_W)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .enable(state_reg.ctrl.divider_enable_bit),
    .tick_in(src_tick),
    .divider_select(state_reg.ctrl.divider_select),
    .tick_out(div_tick)
  );

  // counter tick source: prescaled or raw
  always_comb begin
    if (state_reg.ctrl.divider_enable_bit) begin
      raw_tick = div_tick;
    end else begin
      raw_tick = src_tick;
    end
  end

  // only a running timer takes ticks
  assign run_tick = raw_tick && state_reg.ctrl.count_run_bit;

  // next counter value on a tick: wrap after the limit, else step up
  always_comb begin
    at_limit = (state_reg.count == state_reg.limit);
    count_inc = state_reg.count + `TMR_DATA_W'(1);
    if (at_limit) begin
      count_stepped = '0;
    end else begin
      count_stepped = count_inc;
    end
  end

  // control word as written; bits 5 to 17 are dropped
  always_comb begin
    ctrl_written.count_run_bit = req.wdata[`TMR_RUN_BIT];
    ctrl_written.divider_enable_bit = req.wdata[`TMR_DIV_EN_BIT];
    ctrl_written.divider_select = req.wdata[`TMR_DIV_SEL_MSB:`TMR_DIV_SEL_LSB];
  end

  // control read-back: bits 5 to 17 always zero
  assign ctrl_readback = {13'h0, state_reg.ctrl};

  // read multiplexer; unused control bits and unmapped addresses read zero
  always_comb begin
    read_value = '0;
    if (hit) begin
      case (rel_addr)
        `TMR_OFS_CONTROL: read_value = ctrl_readback;
        `TMR_OFS_LIMIT: read_value = state_reg.limit;
        `TMR_OFS_COUNT: read_value = state_reg.count;
        default: read_value = '0;
      endcase
    end
  end

  // next state
  always_comb begin
    state_next = state_reg;
    state_next.src_prev = src_level;

    // control writes keep only the five defined bits
    if (wr_ctrl) begin
      state_next.ctrl = ctrl_written;
    end

    // limit is a plain read/write register
    if (wr_limit) begin
      state_next.limit = req.wdata;
    end

    // software load wins over a tick in the same cycle
    if (wr_count) begin
      state_next.count = req.wdata;
    end else if (run_tick) begin
      state_next.count = count_stepped;
    end

    // read data is captured on the read strobe and held until the next one
    if (req.rd) begin
      state_next.rdata = read_value;
    end
  end

  // state register; limit has no defined reset value, zero is used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.ctrl <= `TMR_CTRL_RESET;
      state_reg.limit <= `TMR_LIMIT_RESET;
      state_reg.count <= `TMR_COUNT_RESET;
      state_reg.src_prev <= 1'b0;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // counter value straight from its flip-flops
  assign timer_output = state_reg.count;

  // read data held from the last read strobe
  assign bus_rdata = state_reg.rdata;

  // one cycle high for every counter advance or wrap
  assign count_tick = run_tick;

endmodule : prescaled_interval_timer

/* sim/interval_timer_monitor.sv */
// port checker of the prescaled interval timer
// assumes binding into every prescaled_interval_timer
`timescale 1ns/1ps
module interval_timer_monitor
  import interval_timer_pkg::*;
#(parameter logic [17:0] base_offset_param = 18'h00010) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [17:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [17:0] bus_wdata,
  input wire logic [17:0] bus_rdata,
  input wire logic clock_manager_output,
  input wire logic cascade_in,
  input wire logic [17:0] timer_output,
  input wire logic count_tick
);
  // first register word
  wire logic [17:0] ba = 18'h1A000 + base_offset_param;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus side
  AST_RD_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("rdata moved");
  AST_CTRL_RD: assert property (bus_rd && bus_addr == ba |=> bus_rdata[17:5] == 13'h0)
    else $error("ctrl high bits");
  AST_UNMAP: assert property (bus_rd && bus_addr == ba + 18'h3 |=> bus_rdata == 18'h0)
    else $error("unmapped read");
  AST_LIMIT: assert property ((bus_wr && bus_addr == ba + 18'h1) ##1
    (bus_rd && !bus_wr && bus_addr == ba + 18'h1) |=> bus_rdata == $past(bus_wdata, 2))
    else $error("limit readback");
  // counter side
  AST_LOAD: assert property (bus_wr && bus_addr == ba + 18'h2 |=> timer_output == $past(bus_wdata))
    else $error("count load");
  AST_STEP: assert property (count_tick && !bus_wr |=>
    timer_output == $past(timer_output) + 18'h1 || timer_output == 18'h0)
    else $error("count step");
  AST_HOLD: assert property (!count_tick && !bus_wr |=> $stable(timer_output))
    else $error("count drift");
  AST_STOP: assert property (bus_wr && bus_addr == ba && !bus_wdata[0] |=> !count_tick)
    else $error("tick when stopped");
endmodule : interval_timer_monitor

bind prescaled_interval_timer interval_timer_monitor #(.base_offset_param(base_offset_param))
  i_mon (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .clock_manager_output(clock_manager_output),
  .cascade_in(cascade_in), .timer_output(timer_output), .count_tick(count_tick));

/* sim/tick_source_model.sv */
// far-side tick sources: clock manager output and a cascaded timer bit
// assumes the timer's clock
`timescale 1ns/1ps
module tick_source_model (
  input wire logic clk,
  output logic cm_level = 1'b0,
  output logic cas_level = 1'b0
);
  int n = 0;
  // square waves of 6 and 12 clocks
  always @(posedge clk) begin
    n <= n + 1;
    cm_level <= n % 6 > 2;
    cas_level <= n % 12 > 5;
  end
endmodule : tick_source_model

/* sim/prescaled_interval_timer_tb.sv */
// self-checking bench of the prescaled interval timer
// assumes default base offset; one instance per build-time tick source
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"
module prescaled_interval_timer_tb;
  import interval_timer_pkg::*;
  localparam logic [17:0] ba = `TMR_PERIPH_BASE + `TMR_BASE_OFFSET;
  logic clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, cmo, cas, tick;
  logic [17:0] bus_addr = 18'h0, bus_wdata = 18'h0, bus_rdata, timer_output;
  logic [17:0] out_cm, out_cas;
  int err_total = 0, compares = 0, cyc = 0;
  // control, limit, source ticks, expected count
  int rows [10][4] = '{'{5'h01, 3'h3, 10'h00A, 2'h2}, '{5'h02, 3'h7, 10'h008, 2'h0},
    '{5'h03, 3'h7, 10'h007, 2'h3}, '{5'h07, 3'h7, 10'h00F, 2'h3},
    '{5'h0B, 3'h7, 10'h01F, 2'h3}, '{5'h0F, 3'h7, 10'h03F, 2'h3},
    '{5'h13, 3'h7, 10'h07F, 2'h3}, '{5'h17, 3'h7, 10'h0FF, 2'h3},
    '{5'h1B, 3'h7, 10'h1FF, 2'h3}, '{5'h1F, 3'h7, 10'h3FF, 2'h3}};

  prescaled_interval_timer i_dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .clock_manager_output(cmo), .cascade_in(cas), .timer_output(timer_output),
    .count_tick(tick));
  tick_source_model i_src (.clk(clk), .cm_level(cmo), .cas_level(cas));
  // same bus, other build-time sources
  prescaled_interval_timer #(.SOURCE(SRC_CLOCK_MANAGER)) i_dut_cm (.clk(clk), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(), .clock_manager_output(cmo), .cascade_in(cas), .timer_output(out_cm),
    .count_tick());
  prescaled_interval_timer #(.SOURCE(SRC_CASCADE)) i_dut_cas (.clk(clk), .rst_n(rst_n),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(), .clock_manager_output(cmo), .cascade_in(cas), .timer_output(out_cas),
    .count_tick());

  always #2.5 clk = ~clk;

  // one bus cycle; strobes stay up until the next call
  task automatic acc(input logic w, r, input logic [17:0] a, d);
    bus_wr = w;
    bus_rd = r;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    #1;
  endtask : acc

  task automatic idle(input int n);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic chk(input logic [17:0] seen, exp, input string nm);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task complete_run;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(1);
    // run each row from zero, stop, read back
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, ba + 18'h2, 18'h0);
      acc(1'b1, 1'b0, ba + 18'h1, 18'(rows[i][1]));
      acc(1'b1, 1'b0, ba, 18'(rows[i][0]));
      idle(rows[i][2] - 1);
      acc(1'b1, 1'b0, ba, 18'h0);
      acc(1'b0, 1'b1, ba + 18'h2, 18'h0);
      chk(bus_rdata, 18'(rows[i][3]), "count");
      chk(timer_output, 18'(rows[i][3]), "out");
    end
    // limit readback, masked control, unmapped word
    acc(1'b1, 1'b0, ba + 18'h1, 18'h2AAAA);
    acc(1'b0, 1'b1, ba + 18'h1, 18'h0);
    chk(bus_rdata, 18'h2AAAA, "limit");
    acc(1'b1, 1'b0, ba, 18'h3FFFF);
    acc(1'b0, 1'b1, ba, 18'h0);
    chk(bus_rdata, 18'h0001F, "ctrl");
    acc(1'b1, 1'b0, ba + 18'h3, 18'h3FFFF);
    acc(1'b0, 1'b1, ba + 18'h3, 18'h0);
    chk(bus_rdata, 18'h0, "unmapped");
    // count write beats a tick, then holds once stopped
    acc(1'b1, 1'b0, ba + 18'h1, 18'h3FFFF);
    acc(1'b1, 1'b0, ba, 18'h00001);
    acc(1'b1, 1'b0, ba + 18'h2, 18'h00100);
    chk(timer_output, 18'h00100, "load");
    acc(1'b1, 1'b0, ba, 18'h0);
    idle(3);
    acc(1'b0, 1'b1, ba + 18'h2, 18'h0);
    chk(bus_rdata, 18'h00101, "held");
    // 24 run cycles: 24 system ticks, 4 of period 6, 2 of period 12
    acc(1'b1, 1'b0, ba + 18'h2, 18'h0);
    acc(1'b1, 1'b0, ba, 18'h00001);
    chk(18'(tick), 18'h1, "tick run");
    idle(23);
    acc(1'b1, 1'b0, ba, 18'h0);
    chk(18'(tick), 18'h0, "tick stop");
    chk(timer_output, 18'h00018, "sys src");
    chk(out_cm, 18'h00004, "cm src");
    chk(out_cas, 18'h00002, "cas src");
    // reset while running
    acc(1'b1, 1'b0, ba, 18'h00007);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(3);
    chk(timer_output, 18'h0, "out rst");
    acc(1'b0, 1'b1, ba, 18'h0);
    chk(bus_rdata, 18'h0, "ctrl rst");
    complete_run();
  end
endmodule : prescaled_interval_timer_tb
